/* File: pot_wiper_ctrl.sv */
// Dual log pot wiper controller: serial port, push-buttons, mute, zero-cross.
// Assumes clk_i free-running at 40 MHz; sclk_i runs only inside frames.
//
// Contract
// RULE1: Transaction starts on port select rising.
// RULE2: Sample data on rising serial clock while selected.
// RULE3: One 16-bit register, two 8-bit fields.
// RULE4: Position bits per channel; bit 7/15 mutes.
// RULE5: Host sends LSB first, channel 0 first.
// RULE6: Host clocks full 16 bits per device.
// RULE7: Select falling loads register into wipers.
// RULE8: Attenuate steps toward output; gain toward input.
// RULE9: Falling button edge starts a press.
// RULE10: Press qualifies by mode minimum, 0.8 s max.
// RULE11: Host spaces presses by mode minimum.
// RULE12: Held beyond 0.8 s, step every 25 ms.
// RULE13: Mode pin sampled once after power-up.
// RULE14: Gated load waits zero crossing or 50 ms.
// RULE15: Gate input high bypasses wait and timeout.
// RULE16: Button steps wait zero crossing or 50 ms.
// RULE17: Held press changes gated the same way.
// RULE18: Mute button toggles both wipers to 128.
// RULE19: Any gain/attenuate press cancels hardware mute.
// RULE20: Host clears bits 7 and 15 to unmute.
// RULE21: Cascade output shows bit leaving the register.
// RULE22: Cascade shows bit 0 on select rising.
// RULE23: Both wipers start at position 127.
// RULE24: Port disabled while select is low.
// RULE25: Button timing from internal time base only.
module pot_wiper_ctrl import pot_ctrl_pkg::*; #(
  parameter logic [TIMER_W-1:0] FAST_MIN_T = FAST_MIN_TICKS,
  parameter logic [TIMER_W-1:0] SLOW_MIN_T = SLOW_MIN_TICKS,
  parameter logic [TIMER_W-1:0] HOLD_T = HOLD_TICKS,
  parameter logic [TIMER_W-1:0] REPEAT_T = REPEAT_TICKS,
  parameter logic [TIMER_W-1:0] ZC_TIMEOUT_T = ZC_TIMEOUT_TICKS
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic port_reset_n_i,
  input wire logic sdata_i,
  output logic cout_o,
  input wire logic ch0_atten_button_n_i,
  input wire logic ch0_gain_button_n_i,
  input wire logic ch1_atten_button_n_i,
  input wire logic ch1_gain_button_n_i,
  input wire logic mute_button_n_i,
  input wire logic mode_slow_i,
  input wire logic zero_cross_gate_n_i,
  input wire logic zero_cross_i,
  output logic [7:0] wiper0_o,
  output logic [7:0] wiper1_o,
  output logic update_pending_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] shreg_ff;
  logic started_ff;
  logic edge_tgl_ff;
  logic [WORD_W-1:0] cur_word;
  logic [WORD_W-1:0] snap_ff;
  logic [SI_W-1:0] async_in;
  logic [SI_W-1:0] sync1_ff;
  logic [SI_W-1:0] sync2_ff;
  logic sel_q_ff;
  logic zc_q_ff;
  logic tgl_seen_ff;
  logic sel_fall;
  logic load_evt;
  logic zc_evt;
  logic gate_on;
  logic [TICK_CNT_W-1:0] tick_cnt_ff;
  logic tick;
  logic [1:0] init_cnt_ff;
  logic mode_caught;
  logic slow_ff;
  logic [TIMER_W-1:0] min_t;
  logic [NUM_BTN-1:0] step;
  logic btn_any;
  logic hw_mute_ff;
  logic [WORD_W-1:0] applied_ff;
  logic [WORD_W-1:0] target_ff;
  logic pending_ff;
  logic [TIMER_W-1:0] zc_timer_ff;
  logic timer_done;
  logic [WORD_W-1:0] base_word;
  logic [WORD_W-1:0] btn_word;
  logic [7:0] wiper0_ff;
  logic [7:0] wiper1_ff;

  // Saturating one-position move of a 7-bit wiper field
  function automatic logic [POS_W-1:0] step_pos(input logic [POS_W-1:0] pos,
                                               input logic atten, input logic gain);
    logic [POS_W-1:0] res;
    res = pos;
    if (atten && !gain && pos != POS_MAX) begin
      res = pos + 1'b1; // see RULE8
    end else if (gain && !atten && pos != POS_MIN) begin
      res = pos - 1'b1; // see RULE8
    end
    return res;
  endfunction : step_pos

  // ----------------------------------------------------------------
  // Link domain (serial clock)
  // ----------------------------------------------------------------
  // Before the first edge of a frame the register shows the snapshot
  // of the live settings, which clk_i holds still while selected
  assign cur_word = started_ff ? shreg_ff : snap_ff; // see RULE22
  assign cout_o = cur_word[0]; // see RULE21

  // Frame-start flag, cleared by the select line itself since sclk stops
  always_ff @(posedge sclk_i or negedge port_reset_n_i) begin
    if (!port_reset_n_i) begin
      started_ff <= 1'b0; // see RULE1
    end else begin
      started_ff <= 1'b1;
    end
  end

  // Shift LSB first; data enters at the top, bit 0 leaves at cout
  always_ff @(posedge sclk_i) begin
    if (port_reset_n_i) begin // see RULE24
      shreg_ff <= {sdata_i, cur_word[WORD_W-1:1]}; // see RULE2
    end
  end

  // Toggles once per frame that saw clocks; tells clk_i a new word exists
  always_ff @(posedge sclk_i or posedge srst_i) begin
    if (srst_i) begin
      edge_tgl_ff <= 1'b0;
    end else if (port_reset_n_i && !started_ff) begin
      edge_tgl_ff <= ~edge_tgl_ff;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers into clk_i
  // ----------------------------------------------------------------
  assign async_in = {zero_cross_i, zero_cross_gate_n_i, mode_slow_i, mute_button_n_i,
                     ch1_gain_button_n_i, ch1_atten_button_n_i, ch0_gain_button_n_i,
                     ch0_atten_button_n_i, edge_tgl_ff, port_reset_n_i};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1_ff <= SYNC_RESET;
      sync2_ff <= SYNC_RESET;
    end else if (ce_i) begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Edge history of the synchronised levels
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_q_ff <= 1'b0;
      zc_q_ff <= 1'b0;
      tgl_seen_ff <= 1'b0;
    end else if (ce_i) begin
      sel_q_ff <= sync2_ff[SI_SEL];
      zc_q_ff <= sync2_ff[SI_ZC];
      if (sel_fall) begin
        tgl_seen_ff <= sync2_ff[SI_TGL];
      end
    end
  end

  assign sel_fall = sel_q_ff && !sync2_ff[SI_SEL];
  // A frame with no clocks reloads the unchanged settings, so skip it
  assign load_evt = sel_fall && (sync2_ff[SI_TGL] != tgl_seen_ff); // see RULE7
  assign zc_evt = sync2_ff[SI_ZC] && !zc_q_ff;
  assign gate_on = !sync2_ff[SI_GATE]; // see RULE15

  // ----------------------------------------------------------------
  // Time base and mode capture
  // ----------------------------------------------------------------
  // Free-running 1 us tick, independent of the serial clock
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tick_cnt_ff <= '0;
    end else if (ce_i) begin
      if (tick) begin
        tick_cnt_ff <= '0;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 1'b1; // see RULE25
      end
    end
  end
  assign tick = (tick_cnt_ff == TICK_CNT_W'(TICK_CYC - 1));

  // Mode follows the pin only until the synchroniser has filled
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      init_cnt_ff <= '0;
      slow_ff <= 1'b0;
    end else if (ce_i && !mode_caught) begin
      init_cnt_ff <= init_cnt_ff + 1'b1;
      slow_ff <= sync2_ff[SI_MODE]; // see RULE13
    end
  end
  assign mode_caught = (init_cnt_ff == MODE_CATCH_CYC);
  assign min_t = slow_ff ? SLOW_MIN_T : FAST_MIN_T; // see RULE10

  // ----------------------------------------------------------------
  // Button qualifiers: ch0 atten, ch0 gain, ch1 atten, ch1 gain, mute
  // ----------------------------------------------------------------
  generate
    for (genvar b = 0; b < NUM_BTN; b++) begin : g_btn
      btn_qualifier #(
        .REPEAT_EN(b != BTN_MUTE),
        .HOLD_T(HOLD_T),
        .REPEAT_T(REPEAT_T)
      ) u_qual (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .tick_i(tick),
        .pressed_i(!sync2_ff[SI_BTN + b]),
        .min_t_i(min_t),
        .step_o(step[b])
      );
    end
  endgenerate

  assign btn_any = |step[BTN_MUTE-1:0];

  // ----------------------------------------------------------------
  // Hardware mute toggle
  // ----------------------------------------------------------------
  // Mute only overlays the outputs, so the prior positions survive it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hw_mute_ff <= 1'b0;
    end else if (ce_i) begin
      if (btn_any) begin
        hw_mute_ff <= 1'b0; // see RULE19
      end else if (step[BTN_MUTE]) begin
        hw_mute_ff <= ~hw_mute_ff; // see RULE18
      end
    end
  end

  // ----------------------------------------------------------------
  // Wiper update with zero-cross gating
  // ----------------------------------------------------------------
  // Button steps build on a change that is still waiting
  assign base_word = pending_ff ? target_ff : applied_ff;
  always_comb begin
    btn_word = base_word;
    btn_word[CH0_POS_LSB +: POS_W] = step_pos(base_word[CH0_POS_LSB +: POS_W],
                                              step[0], step[1]);
    btn_word[CH1_POS_LSB +: POS_W] = step_pos(base_word[CH1_POS_LSB +: POS_W],
                                              step[2], step[3]);
  end

  // A serial load in the same cycle as a button step wins over it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      applied_ff <= RESET_WORD; // see RULE23
      target_ff <= RESET_WORD;
      pending_ff <= 1'b0;
    end else if (ce_i) begin
      if (load_evt || btn_any) begin
        if (gate_on) begin
          target_ff <= load_evt ? shreg_ff : btn_word; // see RULE16
          pending_ff <= 1'b1; // see RULE14
        end else begin
          applied_ff <= load_evt ? shreg_ff : btn_word; // see RULE3
          pending_ff <= 1'b0;
        end
      end else if (pending_ff && (zc_evt || timer_done || !gate_on)) begin
        applied_ff <= target_ff; // see RULE17
        pending_ff <= 1'b0;
      end
    end
  end

  // Timeout restarts with every new change
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      zc_timer_ff <= '0;
    end else if (ce_i) begin
      if (load_evt || btn_any) begin
        zc_timer_ff <= '0;
      end else if (pending_ff && tick && !timer_done) begin
        zc_timer_ff <= zc_timer_ff + 1'b1;
      end
    end
  end
  assign timer_done = (zc_timer_ff == ZC_TIMEOUT_T); // see RULE14

  // Read-back snapshot, frozen while the port is selected
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      snap_ff <= RESET_WORD;
    end else if (ce_i && !sync2_ff[SI_SEL] && !sel_q_ff) begin
      snap_ff <= applied_ff; // see RULE22
    end
  end

  // ----------------------------------------------------------------
  // Wiper outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wiper0_ff <= {1'b0, RESET_WORD[CH0_POS_LSB +: POS_W]};
      wiper1_ff <= {1'b0, RESET_WORD[CH1_POS_LSB +: POS_W]};
    end else if (ce_i) begin
      wiper0_ff <= (hw_mute_ff || applied_ff[CH0_MUTE_BIT]) ? POS_MUTE // see RULE4
                   : {1'b0, applied_ff[CH0_POS_LSB +: POS_W]};
      wiper1_ff <= (hw_mute_ff || applied_ff[CH1_MUTE_BIT]) ? POS_MUTE // see RULE4
                   : {1'b0, applied_ff[CH1_POS_LSB +: POS_W]};
    end
  end

  assign wiper0_o = wiper0_ff;
  assign wiper1_o = wiper1_ff;
  assign update_pending_o = pending_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_gated_change;
    ce_i && (load_evt || btn_any) && gate_on;
  endsequence

  sequence s_release;
    ce_i && pending_ff && !load_evt && !btn_any;
  endsequence

  AST_SHIFT_IN: assert property (@(posedge sclk_i) disable iff (srst_i) // see RULE2
    port_reset_n_i |=> shreg_ff[WORD_W-1] == $past(sdata_i))
    else $error("serial data not shifted in at top");

  AST_COUT_FIRST: assert property (@(posedge sclk_i) disable iff (srst_i) // see RULE22
    (port_reset_n_i && !started_ff) |=> shreg_ff[WORD_W-2:0] == $past(snap_ff[WORD_W-1:1]))
    else $error("first shift did not start from current settings");

  AST_GATED_WAIT: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE14
    s_gated_change |=> pending_ff && applied_ff == $past(applied_ff))
    else $error("gated change applied without waiting");

  AST_BYPASS: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE15
    (ce_i && load_evt && !gate_on) |=> !pending_ff && applied_ff == $past(shreg_ff))
    else $error("ungated load not applied at once");

  AST_TIMEOUT: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE16
    s_release ##0 timer_done |=> !pending_ff && applied_ff == $past(target_ff))
    else $error("timeout did not apply pending change");

  AST_ZC_APPLY: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE17
    s_release ##0 zc_evt |=> !pending_ff && applied_ff == $past(target_ff))
    else $error("zero crossing did not apply pending change");

  AST_TIMER_BOUND: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE14
    pending_ff |-> zc_timer_ff <= ZC_TIMEOUT_T)
    else $error("zero-cross timer ran past timeout");

  AST_HW_MUTE: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE18
    (ce_i && hw_mute_ff) |=> wiper0_o == POS_MUTE && wiper1_o == POS_MUTE)
    else $error("hardware mute not shown on wipers");

  AST_SOFT_MUTE: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE4
    (ce_i && applied_ff[CH1_MUTE_BIT]) |=> wiper1_o == POS_MUTE)
    else $error("software mute not shown on channel 1");

  AST_CANCEL_MUTE: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE19
    (ce_i && btn_any) |=> !hw_mute_ff)
    else $error("button press left hardware mute engaged");

  AST_MODE_FIXED: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE13
    mode_caught |=> $stable(slow_ff) && mode_caught)
    else $error("timing mode changed after capture");

endmodule : pot_wiper_ctrl

/* File: pot_ctrl_pkg.sv */
// Shared constants for the dual log pot wiper controller.
// Assumes a 40 MHz system clock; all push-button timing runs on a 1 us tick.
package pot_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 6;
  localparam int TIMER_W = 20;

  // ----------------------------------------------------------------
  // Push-button and zero-cross timing, in printed units
  // ----------------------------------------------------------------
  localparam int FAST_MIN_US = 50;
  localparam int SLOW_MIN_MS = 1;
  localparam int HOLD_MS = 800;
  localparam int REPEAT_MS = 25;
  localparam int ZC_TIMEOUT_MS = 50;

  // Same times as counts of 1 us ticks
  localparam logic [TIMER_W-1:0] FAST_MIN_TICKS = TIMER_W'(FAST_MIN_US * 1000 / TICK_NS);
  localparam logic [TIMER_W-1:0] SLOW_MIN_TICKS = TIMER_W'(SLOW_MIN_MS * 1000000 / TICK_NS);
  localparam logic [TIMER_W-1:0] HOLD_TICKS = TIMER_W'(HOLD_MS * 1000000 / TICK_NS);
  localparam logic [TIMER_W-1:0] REPEAT_TICKS = TIMER_W'(REPEAT_MS * 1000000 / TICK_NS);
  localparam logic [TIMER_W-1:0] ZC_TIMEOUT_TICKS = TIMER_W'(ZC_TIMEOUT_MS * 1000000 / TICK_NS);

  // ----------------------------------------------------------------
  // Wiper shift register layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int POS_W = 7;
  localparam int CH0_POS_LSB = 0;
  localparam int CH0_MUTE_BIT = 7;
  localparam int CH1_POS_LSB = 8;
  localparam int CH1_MUTE_BIT = 15;
  localparam logic [WORD_W-1:0] RESET_WORD = 16'h7f7f;
  localparam logic [7:0] POS_MUTE = 8'h80;
  localparam logic [POS_W-1:0] POS_MAX = 7'h7f;
  localparam logic [POS_W-1:0] POS_MIN = 7'h00;

  // ----------------------------------------------------------------
  // Synchroniser bit positions and reset value
  // ----------------------------------------------------------------
  localparam int SI_SEL = 0;
  localparam int SI_TGL = 1;
  localparam int SI_BTN = 2;
  localparam int NUM_BTN = 5;
  localparam int BTN_MUTE = 4;
  localparam int SI_MODE = 7;
  localparam int SI_GATE = 8;
  localparam int SI_ZC = 9;
  localparam int SI_W = 10;
  localparam logic [SI_W-1:0] SYNC_RESET = 10'h07c;
  localparam logic [1:0] MODE_CATCH_CYC = 2'h3;

  typedef enum logic [1:0] {
    BTN_IDLE = 2'b00,
    BTN_PRESS = 2'b01,
    BTN_HOLD = 2'b10,
    BTN_GAP = 2'b11
  } btn_state_type;

endpackage : pot_ctrl_pkg

/* File: btn_qualifier.sv */
// Push-button pulse qualifier: turns one synchronised button level into
// one-cycle step pulses. Assumes a 1 us tick and the pressed level on clk_i.
module btn_qualifier import pot_ctrl_pkg::*; #(
  parameter bit REPEAT_EN = 1'b1,
  parameter logic [TIMER_W-1:0] HOLD_T = HOLD_TICKS,
  parameter logic [TIMER_W-1:0] REPEAT_T = REPEAT_TICKS
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic pressed_i,
  input wire logic [TIMER_W-1:0] min_t_i,
  output logic step_o
);

  btn_state_type state_ff;
  logic [TIMER_W-1:0] cnt_ff;
  logic step_ff;

  // ----------------------------------------------------------------
  // Press / hold / release-gap sequencing
  // ----------------------------------------------------------------
  // Starts in the gap so a button held through reset is not a press
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      step_ff <= 1'b0;
      state_ff <= BTN_GAP;
      cnt_ff <= '0;
    end else if (ce_i) begin
      step_ff <= 1'b0; // Held through ce_i low so a frozen consumer keeps it
      case (state_ff)
        BTN_IDLE: begin
          if (pressed_i) begin // see RULE9
            state_ff <= BTN_PRESS;
            cnt_ff <= '0;
          end
        end
        BTN_PRESS: begin
          if (!pressed_i) begin
            state_ff <= BTN_GAP;
            cnt_ff <= '0;
          end else if (tick_i) begin
            cnt_ff <= cnt_ff + 1'b1;
            if (cnt_ff == min_t_i) begin
              step_ff <= 1'b1; // see RULE10
              state_ff <= BTN_HOLD;
            end
          end
        end
        BTN_HOLD: begin
          if (!pressed_i) begin
            state_ff <= BTN_GAP;
            cnt_ff <= '0;
          end else if (tick_i) begin
            if (cnt_ff == HOLD_T) begin
              // Rewind one repeat period so the next step lands 25 ms later
              step_ff <= REPEAT_EN; // see RULE12
              cnt_ff <= HOLD_T - REPEAT_T;
            end else begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end
        end
        BTN_GAP: begin
          // Bounce during the gap restarts it
          if (pressed_i) begin
            cnt_ff <= '0;
          end else if (tick_i) begin
            cnt_ff <= cnt_ff + 1'b1;
            if (cnt_ff == min_t_i) begin
              state_ff <= BTN_IDLE;
            end
          end
        end
        default: begin
          state_ff <= BTN_GAP;
        end
      endcase
    end
  end

  assign step_o = step_ff;

endmodule : btn_qualifier

/* File: serial_host_model.sv */
// Host side of the three-wire port: frames one word LSB first, reads cascade.
// Assumes the testbench calls send_word and then looks at read_word.
module serial_host_model (
  output logic sclk_o,
  output logic port_reset_n_o,
  output logic sdata_o,
  input wire logic cout_i
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] read_word;

  // Link clock stands low outside frames; select drops just after time
  // zero so the frame flag sees a real falling edge
  initial begin
    sclk_o = 1'b0;
    port_reset_n_o = 1'b1;
    sdata_o = 1'b1;
    #1 port_reset_n_o = 1'b0;
  end

  // One full frame at an 80 ns link clock; select opens and closes it
  task automatic send_word(input logic [15:0] word);
    int i;
    port_reset_n_o = 1'b1;
    #100;
    for (i = 0; i < 16; i++) begin
      sdata_o = word[i];
      read_word[i] = cout_i;
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    #60 port_reset_n_o = 1'b0;
    // Released line must not keep showing the last bit
    sdata_o = ~sdata_o;
    #200;
  endtask : send_word
endmodule : serial_host_model

/* File: dual_log_pot_wiper_control_tb.sv */
// Self-checking bench: serial loads, zero-cross gating, buttons and mute
// against a behavioural model. Assumes shortened timers; fast mode, then slow.
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module dual_log_pot_wiper_control_tb import pot_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 40; // clk cycles per 1 us tick
  logic clk, srst, gate_n, zc, cout, sclk, sel_n, sdata, upd, ce, mode;
  logic [4:0] btn_n;
  logic [7:0] w0, w1;
  logic [15:0] word_m, last, ow;
  logic [31:0] rng = 32'h2a;
  int err_count = 0;
  int check_count = 0;
  int hw_mute = 0;

  pot_wiper_ctrl #(.FAST_MIN_T(20'h5), .SLOW_MIN_T(20'ha), .HOLD_T(20'hc8),
    .REPEAT_T(20'h14), .ZC_TIMEOUT_T(20'h32)) u_pot_wiper_ctrl (
    .clk_i(clk),
    .srst_i(srst),
    .ce_i(ce),
    .sclk_i(sclk),
    .port_reset_n_i(sel_n),
    .sdata_i(sdata),
    .cout_o(cout),
    .ch0_atten_button_n_i(btn_n[0]),
    .ch0_gain_button_n_i(btn_n[1]),
    .ch1_atten_button_n_i(btn_n[2]),
    .ch1_gain_button_n_i(btn_n[3]),
    .mute_button_n_i(btn_n[4]),
    .mode_slow_i(mode),
    .zero_cross_gate_n_i(gate_n),
    .zero_cross_i(zc),
    .wiper0_o(w0),
    .wiper1_o(w1),
    .update_pending_o(upd)
  );

  serial_host_model u_serial_host_model (
    .sclk_o(sclk),
    .port_reset_n_o(sel_n),
    .sdata_o(sdata),
    .cout_i(cout)
  );

  // --------------------------------------------------------------
  // Model and helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic logic [7:0] exp_w(input int ch);
    if (hw_mute != 0 || word_m[8*ch+7]) return 8'h80;
    return {1'b0, word_m[8*ch +: 7]};
  endfunction : exp_w

  // Buttons move positions only; stored mute bits stay put
  function automatic void step(input int ch, input int up);
    int p;
    p = word_m[8*ch +: 7];
    p = up ? (p == 127 ? 127 : p + 1) : (p == 0 ? 0 : p - 1);
    word_m[8*ch +: 7] = 7'(p);
    hw_mute = 0;
  endfunction : step

  task automatic wait_chk(input int lim);
    int n;
    n = 0;
    while (n < lim && (w0 !== exp_w(0) || w1 !== exp_w(1))) begin
      @(negedge clk);
      n++;
    end
    `CHK(w0, exp_w(0))
    `CHK(w1, exp_w(1))
  endtask : wait_chk

  task automatic frame(input logic [15:0] w);
    @(negedge clk);
    u_serial_host_model.send_word(w);
    word_m = w;
  endtask : frame

  task automatic zc_pulse();
    @(negedge clk) zc = 1'b1;
    repeat (4) @(negedge clk);
    zc = 1'b0;
  endtask : zc_pulse

  // Release gap of 10 ticks keeps fast-mode presses distinct
  task automatic btn_step(input int b, input int ticks, input int n);
    @(negedge clk) btn_n[b] = 1'b0;
    repeat (ticks * TK) @(negedge clk);
    btn_n[b] = 1'b1;
    repeat (10 * TK) @(negedge clk);
    repeat (n) begin
      if (b == 4) hw_mute = 1 - hw_mute;
      else step(b / 2, int'(b % 2 == 0));
    end
    wait_chk(20);
  endtask : btn_step

  task automatic final_report();
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // --------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Run needs about 25k cycles; allow three times that
  initial begin
    #2000000;
    err_count++;
    final_report();
  end

  initial begin
    srst = 1'b0;
    gate_n = 1'b1;
    ce = 1'b1;
    mode = 1'b0;
    zc = 1'b0;
    btn_n = 5'h1f;
    word_m = RESET_WORD;
    // Reset rises after time zero so the link-side flag sees its edge
    #1 srst = 1'b1;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    `CHK(w0, 8'h7f)
    `CHK(w1, 8'h7f)
    `CHK(cout, 1'b1)
    repeat (20 * TK) @(negedge clk);
    for (int i = 0; i < 5; i++) begin
      last = word_m;
      frame(16'(xs()));
      wait_chk(20);
      if (i > 0) `CHK(u_serial_host_model.read_word, last)
    end
    frame(16'h8080);
    wait_chk(20);
    frame(16'h2a15);
    wait_chk(20);
    `CHK(u_serial_host_model.read_word, 16'h8080)
    gate_n = 1'b0;
    ow = {exp_w(1), exp_w(0)};
    frame(16'h1234);
    // Clock enable low freezes the gate: a crossing meanwhile is lost
    @(negedge clk) ce = 1'b0;
    zc_pulse();
    ce = 1'b1;
    `CHK(upd, 1'b1)
    `CHK({w1, w0}, ow)
    zc_pulse();
    wait_chk(20);
    ow = {exp_w(1), exp_w(0)};
    frame(16'h0a85);
    repeat (1900) @(negedge clk);
    `CHK({w1, w0}, ow)
    wait_chk(300);
    `CHK(upd, 1'b0)
    frame(16'h0010);
    @(negedge clk) gate_n = 1'b1;
    wait_chk(5);
    btn_step(0, 10, 1);
    btn_step(1, 10, 1);
    btn_step(3, 10, 1);
    btn_step(2, 10, 1);
    btn_step(0, 2, 0);
    btn_step(0, 250, 4);
    btn_step(4, 10, 1);
    btn_step(4, 10, 1);
    btn_step(4, 10, 1);
    btn_step(1, 10, 1);
    @(negedge clk) gate_n = 1'b0;
    ow = {exp_w(1), exp_w(0)};
    btn_step(2, 10, 0);
    step(1, 1);
    `CHK(upd, 1'b1)
    `CHK({w1, w0}, ow)
    zc_pulse();
    wait_chk(20);
    // Second reset with the slow pin: a fast-length press no longer counts
    @(negedge clk) begin
      mode = 1'b1;
      gate_n = 1'b1;
      srst = 1'b1;
    end
    repeat (6) @(negedge clk);
    srst = 1'b0;
    word_m = RESET_WORD;
    hw_mute = 0;
    `CHK(w0, 8'h7f)
    `CHK(w1, 8'h7f)
    `CHK(cout, 1'b1)
    repeat (20 * TK) @(negedge clk);
    btn_step(1, 7, 0);
    // Slow release gap is longer than the bench's fixed one
    repeat (10 * TK) @(negedge clk);
    btn_step(1, 14, 1);
    final_report();
  end
endmodule : dual_log_pot_wiper_control_tb
